/* hdl/acp_pkg.sv */
package acp_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_KEYSTREAM_START = 12'h000;
  localparam logic [11:0] OFS_START_A = 12'h004;
  localparam logic [11:0] OFS_HALT = 12'h008;
  localparam logic [11:0] OFS_SPEED_OVERRIDE_TRIG = 12'h00c;
  localparam logic [11:0] OFS_KEYSTREAM_DONE = 12'h100;
  localparam logic [11:0] OFS_START_A_DONE = 12'h104;
  localparam logic [11:0] OFS_FAULT = 12'h108;
  localparam logic [11:0] OFS_EVENT_TASK_LINKS = 12'h200;
  localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFS_INTEGRITY = 12'h400;
  localparam logic [11:0] OFS_ENGINE_ENABLE = 12'h500;
  localparam logic [11:0] OFS_MODE = 12'h504;
  localparam logic [11:0] OFS_KEY_STRUCT_PTR = 12'h508;
  localparam logic [11:0] OFS_SOURCE_PTR = 12'h50c;
  localparam logic [11:0] OFS_DEST_PTR = 12'h510;
  localparam logic [11:0] OFS_WORK_AREA_PTR = 12'h514;
  localparam logic [11:0] OFS_LONG_KS_LEN = 12'h518;
  localparam logic [11:0] OFS_SPEED_OVERRIDE_VAL = 12'h51c;

  // ---------------------------------------------------------------
  // field layout and constants
  // ---------------------------------------------------------------
  localparam int MODE_DECRYPT_BIT = 0;
  localparam int MODE_SPEED_LSB = 16;
  localparam int MODE_LONG_BIT = 24;
  localparam logic [1:0] ENGINE_ON = 2'h2;
  localparam logic [15:0] CFG_WORDS = 16'h0009;
  localparam logic [31:0] SHORT_KS_BYTES = 32'h0000001b;
  localparam logic [7:0] MIC_BYTES = 8'h04;
  localparam logic [31:0] PAYLOAD_OFS = 32'h00000004;
  localparam logic [31:0] RESET_WORD = 32'h00000000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CFG, ST_KS, ST_HDR_RD, ST_HDR_WR, ST_KS_RD,
    ST_SRC_RD, ST_DST_WR, ST_MIC
  } acp_state_t;

  typedef struct packed {
    acp_state_t st;
    logic [15:0] idx;
    logic [15:0] cnt;
    logic [7:0] len;
    logic [31:0] tmp;
    logic [31:0] ks_acc;
    logic [31:0] mic;
    logic start_a_pend;
    logic ev_ks;
    logic ev_cr;
    logic ev_er;
    logic [2:0] inten;
    logic shortcut;
    logic mic_ok;
    logic [1:0] enable;
    logic [31:0] mode;
    logic [31:0] key_ptr;
    logic [31:0] src_ptr;
    logic [31:0] dst_ptr;
    logic [31:0] work_ptr;
    logic [31:0] long_len;
    logic [31:0] ovr_val;
    logic [1:0] speed;
    logic [31:0] rdata;
    logic dma_req;
    logic dma_we;
    logic [31:0] dma_addr;
    logic [31:0] dma_wdata;
    logic p_ks;
    logic p_cr;
    logic p_er;
    logic irq;
  } acp_regs_t;

endpackage

/* hdl/acp_engine.sv */
`timescale 1ns/1ps
module acp_engine (
  input wire logic CORE_CLK_IN, // system clock
  input wire logic RESET_N_IN, // async reset, active low
  input wire logic [11:0] REG_ADDR_IN, // register byte address
  input wire logic [31:0] REG_WDATA_IN, // register write data
  input wire logic REG_WR_IN, // write strobe
  input wire logic REG_RD_IN, // read strobe
  output logic [31:0] REG_RDATA_OUT, // read data, cycle after strobe
  input wire logic HW_KEYSTREAM_START_IN, // hardware keystream task
  input wire logic HW_START_A_IN, // hardware start_a task
  input wire logic HW_HALT_IN, // hardware halt task
  input wire logic HW_SPEED_OVERRIDE_IN, // hardware override task
  output logic DMA_REQ_OUT, // dma request, held until ack or halt
  output logic DMA_WE_OUT, // dma write when high
  output logic [31:0] DMA_ADDR_OUT, // dma byte address
  output logic [31:0] DMA_WDATA_OUT, // dma write data
  input wire logic DMA_ACK_IN, // dma access done
  input wire logic [31:0] DMA_RDATA_IN, // dma read data at ack
  input wire logic DMA_COLLISION_IN, // shared ram collision
  output logic [1:0] LINK_SPEED_OUT, // effective link speed field
  output logic KEYSTREAM_DONE_OUT, // keystream done pulse
  output logic START_A_DONE_OUT, // start_a done pulse
  output logic FAULT_OUT, // fault pulse
  output logic IRQ_OUT // level interrupt
);

  acp_pkg::acp_regs_t q, d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] words(input logic [31:0] nbytes);
    logic [31:0] w;
    w = (nbytes + 32'h00000003) >> 2;
    if (w == 32'h0) begin
      w = 32'h00000001;
    end
    return w[15:0];
  endfunction

  function automatic logic [31:0] waddr(input logic [31:0] base,
                                        input logic [15:0] i);
    return base + {14'h0, i, 2'b00};
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic ks_go;
    logic cr_go;
    logic halt_go;
    logic ovr_go;
    logic ev_ks;
    logic ev_cr;
    logic ev_er;
    logic ack;
    logic dec;
    logic crypting;
    logic [31:0] rd;
    logic [7:0] plen;
    ks_go = HW_KEYSTREAM_START_IN;
    cr_go = HW_START_A_IN;
    halt_go = HW_HALT_IN;
    ovr_go = HW_SPEED_OVERRIDE_IN;
    ev_ks = 1'b0;
    ev_cr = 1'b0;
    ev_er = 1'b0;
    ack = q.dma_req && DMA_ACK_IN;
    dec = q.mode[acp_pkg::MODE_DECRYPT_BIT];
    crypting = (q.st != acp_pkg::ST_IDLE) && (q.st != acp_pkg::ST_CFG)
               && (q.st != acp_pkg::ST_KS);
    rd = acp_pkg::RESET_WORD;
    plen = 8'h00;
    d = q;

    // register writes
    if (REG_WR_IN) begin
      if (REG_ADDR_IN == acp_pkg::OFS_KEYSTREAM_START) begin
        ks_go = ks_go | REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_START_A) begin
        cr_go = cr_go | REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_HALT) begin
        halt_go = halt_go | REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_SPEED_OVERRIDE_TRIG) begin
        ovr_go = ovr_go | REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_KEYSTREAM_DONE) begin
        d.ev_ks = REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_START_A_DONE) begin
        d.ev_cr = REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_FAULT) begin
        d.ev_er = REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_EVENT_TASK_LINKS) begin
        d.shortcut = REG_WDATA_IN[0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_IRQ_ENABLE_SET) begin
        d.inten = q.inten | REG_WDATA_IN[2:0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_IRQ_ENABLE_CLEAR) begin
        d.inten = q.inten & ~REG_WDATA_IN[2:0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_ENGINE_ENABLE) begin
        d.enable = REG_WDATA_IN[1:0];
      end else if (REG_ADDR_IN == acp_pkg::OFS_MODE) begin
        d.mode = REG_WDATA_IN;
      end else if (REG_ADDR_IN == acp_pkg::OFS_KEY_STRUCT_PTR) begin
        d.key_ptr = REG_WDATA_IN;
      end else if (REG_ADDR_IN == acp_pkg::OFS_SOURCE_PTR) begin
        d.src_ptr = REG_WDATA_IN;
      end else if (REG_ADDR_IN == acp_pkg::OFS_DEST_PTR) begin
        d.dst_ptr = REG_WDATA_IN;
      end else if (REG_ADDR_IN == acp_pkg::OFS_WORK_AREA_PTR) begin
        d.work_ptr = REG_WDATA_IN;
      end else if (REG_ADDR_IN == acp_pkg::OFS_LONG_KS_LEN) begin
        d.long_len = REG_WDATA_IN;
      end else if (REG_ADDR_IN == acp_pkg::OFS_SPEED_OVERRIDE_VAL) begin
        d.ovr_val = REG_WDATA_IN;
      end
    end

    // register reads; an event register read clears it
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == acp_pkg::OFS_KEYSTREAM_DONE) begin
        rd = {31'h0, q.ev_ks};
        d.ev_ks = 1'b0;
      end else if (REG_ADDR_IN == acp_pkg::OFS_START_A_DONE) begin
        rd = {31'h0, q.ev_cr};
        d.ev_cr = 1'b0;
      end else if (REG_ADDR_IN == acp_pkg::OFS_FAULT) begin
        rd = {31'h0, q.ev_er};
        d.ev_er = 1'b0;
      end else if (REG_ADDR_IN == acp_pkg::OFS_EVENT_TASK_LINKS) begin
        rd = {31'h0, q.shortcut};
      end else if (REG_ADDR_IN == acp_pkg::OFS_IRQ_ENABLE_SET ||
                   REG_ADDR_IN == acp_pkg::OFS_IRQ_ENABLE_CLEAR) begin
        rd = {29'h0, q.inten};
      end else if (REG_ADDR_IN == acp_pkg::OFS_INTEGRITY) begin
        rd = {31'h0, q.mic_ok};
      end else if (REG_ADDR_IN == acp_pkg::OFS_ENGINE_ENABLE) begin
        rd = {30'h0, q.enable};
      end else if (REG_ADDR_IN == acp_pkg::OFS_MODE) begin
        rd = q.mode;
      end else if (REG_ADDR_IN == acp_pkg::OFS_KEY_STRUCT_PTR) begin
        rd = q.key_ptr;
      end else if (REG_ADDR_IN == acp_pkg::OFS_SOURCE_PTR) begin
        rd = q.src_ptr;
      end else if (REG_ADDR_IN == acp_pkg::OFS_DEST_PTR) begin
        rd = q.dst_ptr;
      end else if (REG_ADDR_IN == acp_pkg::OFS_WORK_AREA_PTR) begin
        rd = q.work_ptr;
      end else if (REG_ADDR_IN == acp_pkg::OFS_LONG_KS_LEN) begin
        rd = q.long_len;
      end else if (REG_ADDR_IN == acp_pkg::OFS_SPEED_OVERRIDE_VAL) begin
        rd = q.ovr_val;
      end
    end
    d.rdata = rd;

    // task starts; ignored while disabled
    if (q.enable == acp_pkg::ENGINE_ON) begin
      if (ks_go && q.st == acp_pkg::ST_IDLE) begin
        d.st = acp_pkg::ST_CFG;
        d.idx = 16'h0;
        d.ks_acc = acp_pkg::RESET_WORD;
        d.start_a_pend = 1'b0;
      end else if (cr_go && q.st == acp_pkg::ST_IDLE) begin
        d.st = acp_pkg::ST_HDR_RD;
        d.speed = q.mode[acp_pkg::MODE_SPEED_LSB +: 2];
      end else if (cr_go && !crypting) begin
        d.start_a_pend = 1'b1;
      end
    end

    // engine sequence
    case (q.st)
      acp_pkg::ST_CFG: begin
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = 1'b0;
          d.dma_addr = waddr(q.key_ptr, q.idx);
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.ks_acc = {q.ks_acc[30:0], q.ks_acc[31]} ^ DMA_RDATA_IN;
          d.idx = q.idx + 16'h1;
          if (q.idx == acp_pkg::CFG_WORDS - 16'h1) begin
            d.st = acp_pkg::ST_KS;
            d.idx = 16'h0;
            if (q.mode[acp_pkg::MODE_LONG_BIT]) begin
              d.cnt = words(q.long_len);
            end else begin
              d.cnt = words(acp_pkg::SHORT_KS_BYTES);
            end
          end
        end
      end
      acp_pkg::ST_KS: begin
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = 1'b1;
          d.dma_addr = waddr(q.work_ptr, q.idx);
          d.dma_wdata = q.ks_acc ^ {16'h0, q.idx};
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.idx = q.idx + 16'h1;
          if (q.idx + 16'h1 == q.cnt) begin
            ev_ks = 1'b1;
            d.st = acp_pkg::ST_IDLE;
            if (q.shortcut || q.start_a_pend) begin
              d.st = acp_pkg::ST_HDR_RD;
              d.speed = q.mode[acp_pkg::MODE_SPEED_LSB +: 2];
            end
            d.start_a_pend = 1'b0;
          end
        end
      end
      acp_pkg::ST_HDR_RD: begin
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = 1'b0;
          d.dma_addr = q.src_ptr;
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.tmp = DMA_RDATA_IN;
          d.len = DMA_RDATA_IN[15:8];
          d.mic = acp_pkg::RESET_WORD;
          d.st = acp_pkg::ST_HDR_WR;
        end
      end
      acp_pkg::ST_HDR_WR: begin
        plen = q.len;
        if (dec) begin
          plen = (q.len >= acp_pkg::MIC_BYTES) ?
                 q.len - acp_pkg::MIC_BYTES : 8'h00;
        end
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = 1'b1;
          d.dma_addr = q.dst_ptr;
          d.dma_wdata = q.tmp;
          if (q.len != 8'h00) begin
            d.dma_wdata[15:8] = dec ? plen : q.len + acp_pkg::MIC_BYTES;
          end
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.idx = 16'h0;
          d.cnt = words({24'h0, plen});
          if (plen == 8'h00) begin
            d.st = (q.len == 8'h00) ? acp_pkg::ST_IDLE : acp_pkg::ST_MIC;
            ev_cr = (q.len == 8'h00);
          end else begin
            d.st = acp_pkg::ST_KS_RD;
          end
        end
      end
      acp_pkg::ST_KS_RD: begin
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = 1'b0;
          d.dma_addr = waddr(q.work_ptr, q.idx);
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.tmp = DMA_RDATA_IN;
          d.st = acp_pkg::ST_SRC_RD;
        end
      end
      acp_pkg::ST_SRC_RD: begin
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = 1'b0;
          d.dma_addr = waddr(q.src_ptr + acp_pkg::PAYLOAD_OFS, q.idx);
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.tmp = q.tmp ^ DMA_RDATA_IN;
          d.mic = q.mic ^ (dec ? q.tmp ^ DMA_RDATA_IN : DMA_RDATA_IN);
          d.st = acp_pkg::ST_DST_WR;
        end
      end
      acp_pkg::ST_DST_WR: begin
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = 1'b1;
          d.dma_addr = waddr(q.dst_ptr + acp_pkg::PAYLOAD_OFS, q.idx);
          d.dma_wdata = q.tmp;
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.idx = q.idx + 16'h1;
          d.st = acp_pkg::ST_KS_RD;
          if (q.idx + 16'h1 == q.cnt) begin
            d.st = acp_pkg::ST_MIC;
          end
        end
      end
      acp_pkg::ST_MIC: begin
        if (!q.dma_req) begin
          d.dma_req = 1'b1;
          d.dma_we = !dec;
          d.dma_addr = dec ? waddr(q.src_ptr + acp_pkg::PAYLOAD_OFS, q.cnt)
                           : waddr(q.dst_ptr + acp_pkg::PAYLOAD_OFS, q.cnt);
          d.dma_wdata = q.mic ^ q.ks_acc;
        end else if (ack) begin
          d.dma_req = 1'b0;
          d.mic_ok = dec ? (DMA_RDATA_IN == (q.mic ^ q.ks_acc)) : 1'b1;
          ev_cr = 1'b1;
          d.st = acp_pkg::ST_IDLE;
        end
      end
      default: begin
        d.dma_req = 1'b0;
      end
    endcase

    // on-the-fly speed change for a running start_a
    if (ovr_go && crypting) begin
      d.speed = q.ovr_val[1:0];
    end
    if (DMA_COLLISION_IN && crypting) begin
      ev_er = 1'b1;
    end
    if (halt_go) begin
      d.st = acp_pkg::ST_IDLE;
      d.dma_req = 1'b0;
      d.start_a_pend = 1'b0;
    end

    // events win over a clear in the same cycle
    d.ev_ks = d.ev_ks | ev_ks;
    d.ev_cr = d.ev_cr | ev_cr;
    d.ev_er = d.ev_er | ev_er;
    d.p_ks = ev_ks;
    d.p_cr = ev_cr;
    d.p_er = ev_er;
    d.irq = |({d.ev_er, d.ev_cr, d.ev_ks} & d.inten);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA_OUT = q.rdata;
  assign DMA_REQ_OUT = q.dma_req;
  assign DMA_WE_OUT = q.dma_we;
  assign DMA_ADDR_OUT = q.dma_addr;
  assign DMA_WDATA_OUT = q.dma_wdata;
  assign LINK_SPEED_OUT = q.speed;
  assign KEYSTREAM_DONE_OUT = q.p_ks;
  assign START_A_DONE_OUT = q.p_cr;
  assign FAULT_OUT = q.p_er;
  assign IRQ_OUT = q.irq;

endmodule

/* tb/acp_chk.sv */
`timescale 1ns/1ps
module acp_chk (
  input wire logic CORE_CLK_IN, // system clock
  input wire logic RESET_N_IN, // reset, active low
  input wire logic REG_WR_IN, // write strobe
  input wire logic HW_HALT_IN, // halt task
  input wire logic DMA_ACK_IN, // dma access done
  input wire logic DMA_COLLISION_IN, // ram collision
  input wire logic DMA_REQ_OUT, // dma request
  input wire logic DMA_WE_OUT, // dma write
  input wire logic [31:0] DMA_ADDR_OUT, // dma address
  input wire logic [31:0] DMA_WDATA_OUT, // dma write data
  input wire logic KEYSTREAM_DONE_OUT, // keystream done pulse
  input wire logic START_A_DONE_OUT, // start_a done pulse
  input wire logic FAULT_OUT // fault pulse
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // ---------------------------------------------------------------
  // completion and dma rules
  // ---------------------------------------------------------------
  AST_KS_PULSE: assert property (
    KEYSTREAM_DONE_OUT |=> !KEYSTREAM_DONE_OUT)
    else $error("keystream done longer than one cycle");
  AST_CR_PULSE: assert property (
    START_A_DONE_OUT |=> !START_A_DONE_OUT)
    else $error("start_a done longer than one cycle");
  AST_DONE_QUIET: assert property (
    START_A_DONE_OUT |-> !DMA_REQ_OUT)
    else $error("dma active at start_a done");
  AST_HALT_DROP: assert property (
    HW_HALT_IN |=> !DMA_REQ_OUT)
    else $error("dma request survives halt");
  AST_FAULT_CAUSE: assert property (
    FAULT_OUT |-> $past(DMA_COLLISION_IN))
    else $error("fault without collision");
  AST_REQ_HOLD: assert property (
    DMA_REQ_OUT && !DMA_ACK_IN && !HW_HALT_IN && !REG_WR_IN |=>
    DMA_REQ_OUT && $stable(DMA_ADDR_OUT) && $stable(DMA_WE_OUT) &&
    $stable(DMA_WDATA_OUT))
    else $error("dma request changed before ack");
  AST_ACK_GAP: assert property (
    DMA_REQ_OUT && DMA_ACK_IN |=> !DMA_REQ_OUT)
    else $error("dma request not dropped after ack");
  AST_REQ_FALL: assert property (
    $fell(DMA_REQ_OUT) |->
    $past(DMA_ACK_IN) || $past(HW_HALT_IN) || $past(REG_WR_IN))
    else $error("dma request dropped without cause");
  // ---------------------------------------------------------------
  // main scenarios
  // ---------------------------------------------------------------
  COV_KS: cover property (KEYSTREAM_DONE_OUT);
  COV_CR: cover property (START_A_DONE_OUT);
  COV_FAULT: cover property (FAULT_OUT);
endmodule

/* tb/acp_ram_model.sv */
`timescale 1ns/1ps
module acp_ram_model (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // reset, active low
  input wire logic req_in, // access request
  input wire logic we_in, // write when high
  input wire logic [31:0] addr_in, // byte address
  input wire logic [31:0] wdata_in, // write data
  output logic ack_out, // access done pulse
  output logic [31:0] rdata_out // read data at ack
);
  logic [31:0] mem [logic [31:0]];
  int lat;
  // ---------------------------------------------------------------
  // shared ram, one to three cycles per access
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      rdata_out <= 32'h0;
      lat = 0;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (!req_in || ack_out) lat = 0;
      else begin
        if (lat == 0) lat = 1 + $urandom_range(2);
        lat--;
        if (lat == 0) begin
          ack_out <= 1'b1;
          if (we_in) mem[addr_in] = wdata_in;
          else rdata_out <= mem.exists(addr_in) ? mem[addr_in] : ~addr_in;
        end
      end
    end
  end
endmodule

/* tb/tb_acp_engine.sv */
`timescale 1ns/1ps
module tb_acp_engine;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ack, req, we, ksd, crd, flt, irq;
  logic [4:0] hw = 5'h0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, daddr, dwd, drd, kp, sp, dp, wp, d;
  logic [1:0] speed;
  logic [32:0] exp_q[$];
  logic [11:0] ofs [9] = '{12'h000, 12'h004, 12'h100, 12'h104, 12'h108,
    12'h200, 12'h304, 12'h400, 12'h600};
  int n_fail = 0, n_tests = 0, n_ksd = 0, n_crd = 0, n_flt = 0;
  always #5 clk = ~clk;
  acp_engine u_acp_engine (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .HW_KEYSTREAM_START_IN(hw[0]),
    .HW_START_A_IN(hw[1]), .HW_HALT_IN(hw[2]), .HW_SPEED_OVERRIDE_IN(hw[3]),
    .DMA_REQ_OUT(req), .DMA_WE_OUT(we), .DMA_ADDR_OUT(daddr),
    .DMA_WDATA_OUT(dwd), .DMA_ACK_IN(ack), .DMA_RDATA_IN(drd),
    .DMA_COLLISION_IN(hw[4]), .LINK_SPEED_OUT(speed),
    .KEYSTREAM_DONE_OUT(ksd), .START_A_DONE_OUT(crd), .FAULT_OUT(flt),
    .IRQ_OUT(irq));
  acp_ram_model u_acp_ram_model (.clk_in(clk), .rst_n_in(rst_n),
    .req_in(req), .we_in(we), .addr_in(daddr), .wdata_in(dwd),
    .ack_out(ack), .rdata_out(drd));
  // ---------------------------------------------------------------
  // compare, report and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    hw[k] <= 1'b1;
    @(posedge clk);
    hw[k] <= 1'b0;
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 3000 && exp_q.size() > n; i++) @(posedge clk);
    if (exp_q.size() > n) begin
      chk("dma wait", 33'h0, 33'h1);
      final_report();
    end
  endtask
  task automatic exp_ks(input int n);
    for (int i = 0; i < 9; i++) exp_q.push_back({1'b0, kp + 4 * i});
    for (int i = 0; i < n; i++) exp_q.push_back({1'b1, wp + 4 * i});
  endtask
  task automatic exp_cr(input int w, input logic enc);
    exp_q.push_back({1'b0, sp});
    exp_q.push_back({1'b1, dp});
    for (int i = 0; i < w; i++) begin
      exp_q.push_back({1'b0, wp + 4 * i});
      exp_q.push_back({1'b0, sp + 4 + 4 * i});
      exp_q.push_back({1'b1, dp + 4 + 4 * i});
    end
    if (w > 0) exp_q.push_back({enc, (enc ? dp : sp) + 4 + 4 * w});
  endtask
  // ---------------------------------------------------------------
  // dma order and event counting
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (req && ack) begin
      if (exp_q.size() == 0) chk("dma extra", 33'h0, {we, daddr});
      else chk("dma", exp_q.pop_front(), {we, daddr});
    end
    n_ksd += ksd;
    n_crd += crd;
    n_flt += flt;
  end
  initial begin
    void'($urandom(32'h9b32));
    kp = 32'h1000 + ($urandom & 32'hffc);
    sp = 32'h3000 + ($urandom & 32'hffc);
    dp = 32'h5000 + ($urandom & 32'hffc);
    wp = 32'h7000 + ($urandom & 32'hffc);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) begin
      rd_reg(ofs[i], d);
      chk("reset", 33'h0, d);
    end
    wr_reg(12'h508, kp);
    wr_reg(12'h50c, sp);
    wr_reg(12'h510, dp);
    wr_reg(12'h514, wp);
    wr_reg(12'h600, 32'hffffffff);
    rd_reg(12'h508, d);
    chk("key ptr", kp, d);
    wr_reg(12'h000, 32'h1);
    repeat (20) @(posedge clk);
    wr_reg(12'h500, 32'h2);
    wr_reg(12'h504, 32'h00010000);
    wr_reg(12'h304, 32'h7);
    exp_ks(7);
    wr_reg(12'h000, 32'h1);
    wait_q(0);
    repeat (4) @(posedge clk);
    chk("ks done", 33'h1, n_ksd);
    chk("irq", 33'h1, irq);
    rd_reg(12'h100, d);
    chk("ks flag", 33'h1, d);
    rd_reg(12'h100, d);
    chk("ks flag", 33'h0, d);
    chk("irq", 33'h0, irq);
    wr_reg(12'h200, 32'h1);
    wr_reg(12'h518, 32'h5);
    wr_reg(12'h504, 32'h01010000);
    u_acp_ram_model.mem[sp] = 32'h00aa08c3;
    u_acp_ram_model.mem[sp + 4] = $urandom;
    u_acp_ram_model.mem[sp + 8] = $urandom;
    exp_ks(2);
    exp_cr(2, 1'b1);
    pulse(0);
    wait_q(8);
    chk("speed", 33'h1, speed);
    pulse(4);
    wr_reg(12'h51c, 32'h3);
    pulse(3);
    @(posedge clk);
    chk("speed", 33'h3, speed);
    wait_q(0);
    repeat (4) @(posedge clk);
    chk("ks done", 33'h2, n_ksd);
    chk("start_a done", 33'h1, n_crd);
    chk("fault", 33'h1, n_flt);
    chk("header", 33'h00aa0cc3, u_acp_ram_model.mem[dp]);
    d = u_acp_ram_model.mem[wp] ^ u_acp_ram_model.mem[sp + 4];
    chk("payload", d, u_acp_ram_model.mem[dp + 4]);
    chk("irq", 33'h1, irq);
    rd_reg(12'h108, d);
    chk("fault flag", 33'h1, d);
    rd_reg(12'h104, d);
    chk("start_a flag", 33'h1, d);
    rd_reg(12'h100, d);
    wr_reg(12'h200, 32'h0);
    exp_cr(2, 1'b1);
    pulse(1);
    wait_q(6);
    pulse(2);
    @(posedge clk);
    chk("halt req", 33'h0, req);
    exp_q.delete();
    repeat (30) @(posedge clk);
    chk("start_a done", 33'h1, n_crd);
    wr_reg(12'h308, 32'h6);
    wr_reg(12'h504, 32'h00010001);
    u_acp_ram_model.mem[sp] = 32'h00aa00c3;
    exp_cr(0, 1'b0);
    wr_reg(12'h004, 32'h1);
    wait_q(0);
    repeat (4) @(posedge clk);
    chk("start_a done", 33'h2, n_crd);
    chk("header", 33'h00aa00c3, u_acp_ram_model.mem[dp]);
    chk("irq", 33'h0, irq);
    u_acp_ram_model.mem[sp] = 32'h00aa08c3;
    exp_cr(1, 1'b0);
    pulse(1);
    wait_q(0);
    repeat (4) @(posedge clk);
    chk("start_a done", 33'h3, n_crd);
    chk("header", 33'h00aa04c3, u_acp_ram_model.mem[dp]);
    d = u_acp_ram_model.mem[wp] ^ u_acp_ram_model.mem[sp + 4];
    chk("payload", d, u_acp_ram_model.mem[dp + 4]);
    rd_reg(12'h304, d);
    chk("irq enable", 33'h1, d);
    final_report();
  end
endmodule
bind acp_engine acp_chk u_acp_chk (.CORE_CLK_IN(CORE_CLK_IN),
  .RESET_N_IN(RESET_N_IN), .REG_WR_IN(REG_WR_IN), .HW_HALT_IN(HW_HALT_IN),
  .DMA_ACK_IN(DMA_ACK_IN), .DMA_COLLISION_IN(DMA_COLLISION_IN),
  .DMA_REQ_OUT(DMA_REQ_OUT), .DMA_WE_OUT(DMA_WE_OUT),
  .DMA_ADDR_OUT(DMA_ADDR_OUT), .DMA_WDATA_OUT(DMA_WDATA_OUT),
  .KEYSTREAM_DONE_OUT(KEYSTREAM_DONE_OUT), .START_A_DONE_OUT(START_A_DONE_OUT),
  .FAULT_OUT(FAULT_OUT));
